// [rtl/daq_router_pkg.sv]
// Package: register map, field layout and carrier types of the timing signal router
package daq_router_pkg;

  localparam int NUM_TIMING = 7;
  localparam int NUM_EXT = NUM_TIMING + 2;

  // Register byte offsets
  localparam logic [11:0] SRC_SELECT_OFFSET = 12'h0_000;
  localparam logic [11:0] SYNC_CONFIG_OFFSET = 12'h0_004;
  localparam logic [11:0] ROUTE_STATUS_OFFSET = 12'h0_008;
  localparam logic [11:0] COUNTER_CTRL_OFFSET = 12'h0_00C;
  localparam logic [11:0] COUNTER_VALUE_OFFSET = 12'h0_010;

  // Field positions
  localparam int SYNC_MASTER_BIT = 8;
  localparam int CNT_ENABLE_BIT = 0;
  localparam int CNT_GATED_BIT = 1;

  // Timing signal indices
  localparam int SIG_AD_CONV = 0;
  localparam int SIG_AD_TRIGGER = 1;
  localparam int SIG_DA_TRIGGER = 2;
  localparam int SIG_DAC_UPDATE = 3;
  localparam int SIG_COUNTER_SOURCE = 4;
  localparam int SIG_COUNTER_GATE = 5;
  localparam int SIG_DA_START = 6;

  // Reset values
  localparam logic [13:0] SRC_SELECT_RESET = 14'h0_000;
  localparam logic [6:0] PARTICIPATE_RESET = 7'h00;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_AUX_ZERO = 2'b01,
    SRC_AUX_ONE = 2'b10,
    SRC_SYNC_BUS = 2'b11
  } src_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_in_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_out_t;

  typedef struct packed {
    logic [6:0] drive;
    logic [6:0] enable;
  } sync_bus_out_t;

endpackage

// [rtl/daq_timing_signal_router.sv]
// Timing signal router: source multiplexers, sync bus master/slave and gated counter
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Seven distinct timing signals are produced for A/D pacing, D/A update and the counter.
// - Each timing signal can come from its internal generator, either aux input or the bus.
// - Software sets per signal whether it joins the sync bus and whether this board is master.
// - The master drives its chosen timing signals onto the bus; slaves take them from it.
// - Reset puts every selection back to the internal source with no bus or aux routing left.
// - In gated mode the general counter holds its count while the gate is low and resumes.
module daq_timing_signal_router (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB register port
  input wire daq_router_pkg::apb_in_t apbIn,
  output daq_router_pkg::apb_out_t apbOut,
  // Internal timing generators
  input wire logic [6:0] internalTiming,
  // Auxiliary function input pins
  input wire logic auxInputZero,
  input wire logic auxInputOne,
  // Board synchronization bus, split into in, out and enable
  input wire logic [6:0] syncBusIn,
  output daq_router_pkg::sync_bus_out_t syncBusOut,
  // Routed timing signals and general counter value to the acquisition logic
  output logic [6:0] routedTiming,
  output logic [31:0] counterValue
);
  import daq_router_pkg::*;

  typedef struct packed {
    logic [6:0][1:0] srcRequest;
    logic [6:0][1:0] srcActive;
    logic [6:0] participate;
    logic master;
    logic cntEnable;
    logic cntGated;
    logic [31:0] count;
    logic [8:0] syncA;
    logic [8:0] syncB;
    logic [8:0] syncC;
    logic [8:0] extStable;
    logic [6:0] routed;
    sync_bus_out_t busOut;
    apb_out_t apb;
  } state_t;

  state_t state;
  state_t next_state;

  logic [8:0] extRaw;
  logic [6:0] candidate;
  logic [6:0][1:0] effectiveSel;
  logic [31:0] readData;
  logic mapped;
  logic accessDone;

  assign extRaw = {syncBusIn, auxInputOne, auxInputZero};

  // Source value a selection would give, before the glitch guard
  function automatic logic pick(input logic [1:0] sel, input int idx,
                                input logic [6:0] intl, input logic [8:0] ext);
    logic val;
    val = 1'b0;
    case (sel)
      SRC_INTERNAL: val = intl[idx];
      SRC_AUX_ZERO: val = ext[0];
      SRC_AUX_ONE: val = ext[1];
      SRC_SYNC_BUS: val = ext[2 + idx];
      default: val = intl[idx];
    endcase
    return val;
  endfunction

  always_comb begin
    next_state = state;
    readData = 32'h0000_0000;
    mapped = 1'b1;
    accessDone = apbIn.psel && apbIn.penable && state.apb.pready;

    // Three-stage synchroniser; a level counts once the last two stages agree
    next_state.syncA = extRaw;
    next_state.syncB = state.syncA;
    next_state.syncC = state.syncB;
    for (int i = 0; i < NUM_EXT; i++) begin
      if (state.syncB[i] == state.syncC[i]) begin
        next_state.extStable[i] = state.syncC[i];
      end
    end

    for (int i = 0; i < NUM_TIMING; i++) begin
      // A master never listens to the lines it is driving itself
      effectiveSel[i] = state.srcRequest[i];
      if (state.master && state.participate[i] && state.srcRequest[i] == SRC_SYNC_BUS) begin
        effectiveSel[i] = SRC_INTERNAL;
      end
      // Switch only when old and new sources agree, so no extra edge appears
      if (effectiveSel[i] != state.srcActive[i]) begin
        if (pick(effectiveSel[i], i, internalTiming, state.extStable) == state.routed[i]) begin
          next_state.srcActive[i] = effectiveSel[i];
        end
      end
      candidate[i] = pick(state.srcActive[i], i, internalTiming, state.extStable);
      next_state.routed[i] = candidate[i];
      next_state.busOut.enable[i] = state.master && state.participate[i];
      next_state.busOut.drive[i] = state.master && state.participate[i] && candidate[i];
    end

    // Counter counts rising edges of the routed source, held while gated low
    if (state.cntEnable && candidate[SIG_COUNTER_SOURCE] && !state.routed[SIG_COUNTER_SOURCE]) begin
      if (!state.cntGated || state.routed[SIG_COUNTER_GATE]) begin
        next_state.count = state.count + 32'h0000_0001;
      end
    end

    case (apbIn.paddr)
      SRC_SELECT_OFFSET: readData = {18'h0_0000, state.srcRequest};
      SYNC_CONFIG_OFFSET: readData = {24'h00_0000, state.master, state.participate};
      ROUTE_STATUS_OFFSET: readData = {25'h000_0000, state.routed};
      COUNTER_CTRL_OFFSET: readData = {30'h0000_0000, state.cntGated, state.cntEnable};
      COUNTER_VALUE_OFFSET: readData = state.count;
      default: mapped = 1'b0;
    endcase

    // One wait-free access: pready rises in the access phase after setup
    next_state.apb.pready = apbIn.psel && !apbIn.penable;
    if (apbIn.psel && !apbIn.penable) begin
      next_state.apb.prdata = apbIn.pwrite ? 32'h0000_0000 : readData;
      next_state.apb.pslverr = !mapped;
    end else if (accessDone) begin
      next_state.apb.prdata = 32'h0000_0000;
      next_state.apb.pslverr = 1'b0;
    end

    if (accessDone && apbIn.pwrite && mapped) begin
      case (apbIn.paddr)
        SRC_SELECT_OFFSET: next_state.srcRequest = apbIn.pwdata[13:0];
        SYNC_CONFIG_OFFSET: begin
          next_state.participate = apbIn.pwdata[6:0];
          next_state.master = apbIn.pwdata[SYNC_MASTER_BIT];
        end
        COUNTER_CTRL_OFFSET: begin
          next_state.cntEnable = apbIn.pwdata[CNT_ENABLE_BIT];
          next_state.cntGated = apbIn.pwdata[CNT_GATED_BIT];
        end
        // A software load wins over a counted edge in the same cycle
        COUNTER_VALUE_OFFSET: next_state.count = apbIn.pwdata;
        default: next_state.count = next_state.count;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state.srcRequest <= SRC_SELECT_RESET;
      state.srcActive <= SRC_SELECT_RESET;
      state.participate <= PARTICIPATE_RESET;
      state.master <= 1'b0;
      state.cntEnable <= 1'b0;
      state.cntGated <= 1'b0;
      state.count <= COUNTER_RESET;
      state.syncA <= 9'h000;
      state.syncB <= 9'h000;
      state.syncC <= 9'h000;
      state.extStable <= 9'h000;
      state.routed <= 7'h00;
      state.busOut <= '0;
      state.apb <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign apbOut = state.apb;
  assign syncBusOut = state.busOut;
  assign routedTiming = state.routed;
  assign counterValue = state.count;

endmodule // daq_timing_signal_router

// [bench/daq_router_chk.sv]
// Port checker for the timing signal router
`timescale 1ns/1ps
module daq_router_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire daq_router_pkg::apb_in_t apbIn,
  input wire daq_router_pkg::apb_out_t apbOut,
  input wire logic [6:0] internalTiming,
  input wire logic auxInputZero,
  input wire logic auxInputOne,
  input wire logic [6:0] syncBusIn,
  input wire daq_router_pkg::sync_bus_out_t syncBusOut,
  input wire logic [6:0] routedTiming,
  input wire logic [31:0] counterValue
);
  import daq_router_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet;
  // Cycles since any source moved; covers the 4-5 edge synchroniser lag
  always_ff @(posedge core_clk) begin
    if (!rst_n || $changed({internalTiming, auxInputZero, auxInputOne, syncBusIn})) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  property p_rst;
    $rose(rst_n) |-> routedTiming == 7'h00 && syncBusOut == 14'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_rdy;
    apbIn.psel && !apbIn.penable |=> apbOut.pready ##1 !apbOut.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
  property p_drv;
    (syncBusOut.drive & syncBusOut.enable) == (routedTiming & syncBusOut.enable);
  endproperty
  a_drv: assert property (p_drv) else $error("bus drive differs from routed");
  property p_quiet;
    quiet == 3'h7 |-> $stable(routedTiming);
  endproperty
  a_quiet: assert property (p_quiet) else $error("routed edge without cause");
  property p_cnt;
    $changed(counterValue) && !$past(apbIn.psel && apbIn.penable && apbIn.pwrite)
      |-> counterValue == $past(counterValue) + 32'h0000_0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter jumped");
  property p_stat;
    apbOut.pready && !apbIn.pwrite && apbIn.paddr == ROUTE_STATUS_OFFSET
      |-> apbOut.prdata == {25'h000_0000, $past(routedTiming)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_err;
    apbOut.pslverr |-> apbOut.pready && apbOut.prdata == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule // daq_router_chk

bind daq_timing_signal_router daq_router_chk daq_router_chk_i (.core_clk(core_clk),
  .rst_n(rst_n), .apbIn(apbIn), .apbOut(apbOut), .internalTiming(internalTiming),
  .auxInputZero(auxInputZero), .auxInputOne(auxInputOne), .syncBusIn(syncBusIn),
  .syncBusOut(syncBusOut), .routedTiming(routedTiming), .counterValue(counterValue));

// [bench/sync_partner.sv]
// Far board on the sync bus: resolves each line from both boards' drivers
`timescale 1ns/1ps
module sync_partner (
  // Clock
  input wire logic core_clk,
  // Drivers of both boards
  input wire logic [6:0] dutDrive,
  input wire logic [6:0] dutEnable,
  input wire logic [6:0] farLevel,
  input wire logic [6:0] farEnable,
  // Resolved lines
  output logic [6:0] busLine
);
  logic [6:0] lastLine = 7'h00;
  // No pull: an undriven line flips so a stale level is never trusted
  always_comb busLine = (dutEnable & dutDrive) | (~dutEnable & farEnable & farLevel)
    | (~dutEnable & ~farEnable & ~lastLine);
  always_ff @(posedge core_clk) lastLine <= busLine;
endmodule // sync_partner

// [bench/tb.sv]
// Self-checking bench for the timing signal router
`timescale 1ns/1ps
module tb;
  import daq_router_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_in_t apbIn = '0;
  apb_out_t apbOut;
  logic [6:0] internalTiming = 7'h00;
  logic auxInputZero = 1'b0;
  logic auxInputOne = 1'b0;
  logic [6:0] farLevel = 7'h00;
  logic [6:0] farEnable = 7'h7F;
  logic [6:0] busLine;
  sync_bus_out_t syncBusOut;
  logic [6:0] routedTiming;
  logic [31:0] counterValue;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  daq_timing_signal_router daq_timing_signal_router_i (.core_clk(core_clk), .rst_n(rst_n),
    .apbIn(apbIn), .apbOut(apbOut), .internalTiming(internalTiming),
    .auxInputZero(auxInputZero), .auxInputOne(auxInputOne), .syncBusIn(busLine),
    .syncBusOut(syncBusOut), .routedTiming(routedTiming), .counterValue(counterValue));
  sync_partner sync_partner_i (.core_clk(core_clk), .dutDrive(syncBusOut.drive),
    .dutEnable(syncBusOut.enable), .farLevel(farLevel), .farEnable(farEnable),
    .busLine(busLine));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apbIn <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apbIn.penable <= 1'b1;
    do @(posedge core_clk); while (apbOut.pready !== 1'b1);
    rd = apbOut.prdata;
    er = apbOut.pslverr;
    apbIn <= '0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      idle(2);
      internalTiming[4] <= 1'b1;
      idle(2);
      internalTiming[4] <= 1'b0;
    end
    idle(4);
  endtask
  task automatic t_reset;
    chk(32'(routedTiming), 32'h0000_0000);
    chk(32'(syncBusOut), 32'h0000_0000);
    apb(1'b0, SRC_SELECT_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_route;
    internalTiming <= 7'h51;
    apb(1'b1, SRC_SELECT_OFFSET, 32'h0000_00E5);
    idle(8);
    apb(1'b0, ROUTE_STATUS_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0000_0051);
    internalTiming <= 7'h50;
    auxInputZero <= 1'b1;
    auxInputOne <= 1'b1;
    farLevel <= 7'h08;
    idle(8);
    chk(32'(routedTiming), 32'h0000_005F);
  endtask
  task automatic t_master;
    apb(1'b1, SYNC_CONFIG_OFFSET, 32'h0000_0150);
    farEnable <= 7'h2F;
    idle(3);
    chk(32'(syncBusOut.enable), 32'h0000_0050);
    chk(32'(syncBusOut.drive), 32'h0000_0050);
    chk(32'(busLine), 32'h0000_0058);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
  endtask
  task automatic t_count;
    apb(1'b1, COUNTER_VALUE_OFFSET, 32'h0000_0000);
    apb(1'b1, COUNTER_CTRL_OFFSET, 32'h0000_0003);
    pulses(3);
    chk(counterValue, 32'h0000_0000);
    internalTiming[5] <= 1'b1;
    pulses(3);
    chk(counterValue, 32'h0000_0003);
    apb(1'b0, COUNTER_VALUE_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    idle(3000);
    mismatches++;
    test_done;
  end
  initial begin
    idle(20);
    rst_n <= 1'b1;
    idle(1);
    t_reset;
    t_route;
    t_master;
    t_count;
    internalTiming <= 7'h00;
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    idle(1);
    t_reset;
    test_done;
  end
endmodule // tb
